/* hdl/btif_port.sv */
// backplane transmit input port: samples backplane clock and streams, removes filler,
// emits bits with frame marks into a fifo toward the transmitter
// assumes backplane signals are asynchronous to i_clk_sys and far slower
`timescale 1ns/100ps
`include "btif_consts.svh"
module btif_port #(
    parameter int FIFO_DEPTH = `BTIF_FIFO_DEPTH
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic [1:0] i_rate_mode,
    input wire logic [1:0] i_fp_mode,
    input wire logic i_backplane_tx_clock,
    input wire logic i_backplane_pcm_in,
    input wire logic i_backplane_pcm_neg_in,
    input wire logic i_backplane_signalling_in,
    input wire logic i_backplane_frame_pulse,
    output logic o_overflow,
    output logic o_tx_valid,
    input wire logic i_tx_ready,
    output logic o_tx_pcm_pos,
    output logic o_tx_pcm_neg,
    output logic o_tx_sig,
    output logic o_tx_fbit
);
    // ************************************************************
    // input sampling
    // ************************************************************
    logic [4:0] sync_in;
    logic [4:0] s1_q;
    logic [4:0] s2_q;
    logic [4:0] s3_q;
    logic [4:0] stab_q;
    assign sync_in = {i_backplane_tx_clock, i_backplane_pcm_in, i_backplane_pcm_neg_in,
                      i_backplane_signalling_in, i_backplane_frame_pulse};
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            stab_q <= '0;
        end
        else
        begin
            s1_q <= sync_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < 5; i++)
            begin
                if (s2_q[i] == s3_q[i])
                begin
                    stab_q[i] <= s3_q[i];
                end
            end
        end
    end
    logic clk_prev_q;
    logic rise;
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            clk_prev_q <= 1'b0;
        end
        else
        begin
            clk_prev_q <= stab_q[4];
        end
    end
    // data sampled at rising backplane edge, far side moves on falling edge
    assign rise = stab_q[4] && !clk_prev_q;
    logic pcm;
    logic neg;
    logic sig;
    logic fp;
    assign pcm = stab_q[3];
    assign neg = stab_q[2];
    assign sig = stab_q[1];
    assign fp = stab_q[0];
    // ************************************************************
    // frame position counters
    // ************************************************************
    logic e1_mode;
    logic dual_mode;
    assign e1_mode = (btif_pkg::rate_mode_t'(i_rate_mode) == btif_pkg::rate_e1);
    assign dual_mode = (btif_pkg::rate_mode_t'(i_rate_mode) == btif_pkg::rate_dual);
    btif_pkg::frame_state_t state_q;
    logic [2:0] bit_q;
    logic [4:0] chan_q;
    logic [1:0] slot_q;
    logic [1:0] sf_q;
    logic mark_q;
    // fp mode decides which pulses count as alignment; others are ignored once locked
    function automatic logic fp_counts(input logic [1:0] mode, input logic [1:0] sfc);
        fp_counts = (btif_pkg::fp_mode_t'(mode) != btif_pkg::fp_two_superframes)
                    || (sfc == 2'd0);
    endfunction : fp_counts
    logic take;
    logic in_filler;
    assign in_filler = e1_mode && (slot_q == `BTIF_FILLER_SLOT);
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            state_q <= btif_pkg::st_hunt;
            bit_q <= '0;
            chan_q <= '0;
            slot_q <= '0;
            sf_q <= '0;
            mark_q <= 1'b0;
        end
        else if (rise)
        begin
            if (e1_mode)
            begin
                // filler first bit carries the pulse; next byte is channel one
                if (fp)
                begin
                    state_q <= btif_pkg::st_data;
                    slot_q <= `BTIF_FILLER_SLOT;
                    bit_q <= 3'd1;
                    chan_q <= '0;
                    mark_q <= 1'b1;
                end
                else
                begin
                    bit_q <= bit_q + 3'd1;
                    // the mark is spent on the first kept bit after the pulse
                    if (!in_filler)
                    begin
                        mark_q <= 1'b0;
                    end
                    if (bit_q == `BTIF_LAST_BIT)
                    begin
                        slot_q <= slot_q + 2'd1;
                        if (slot_q != `BTIF_FILLER_SLOT)
                        begin
                            chan_q <= (chan_q == `BTIF_CHANNELS - 5'd1) ? '0 : chan_q + 5'd1;
                        end
                    end
                end
            end
            else if (fp && (state_q == btif_pkg::st_hunt || fp_counts(i_fp_mode, sf_q)))
            begin
                // pulse sits on the framing bit; data restarts at channel one
                state_q <= btif_pkg::st_data;
                bit_q <= '0;
                chan_q <= '0;
                sf_q <= sf_q + 2'd1;
            end
            else if (state_q == btif_pkg::st_fbit)
            begin
                state_q <= btif_pkg::st_data;
            end
            else if (state_q == btif_pkg::st_data)
            begin
                bit_q <= bit_q + 3'd1;
                if (bit_q == `BTIF_LAST_BIT)
                begin
                    if (chan_q == `BTIF_CHANNELS - 5'd1)
                    begin
                        chan_q <= '0;
                        state_q <= btif_pkg::st_fbit;
                    end
                    else
                    begin
                        chan_q <= chan_q + 5'd1;
                    end
                end
            end
        end
    end
    // ************************************************************
    // output staging
    // ************************************************************
    // e1 has no framing bit slot: the frame mark rides on channel one's first bit
    assign take = rise && (state_q != btif_pkg::st_hunt) && !in_filler && !(e1_mode && fp);
    logic [3:0] wdata;
    logic wr_ready;
    assign wdata = {pcm, dual_mode ? neg : 1'b0, sig,
                    e1_mode ? mark_q : (state_q == btif_pkg::st_fbit)};
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            o_overflow <= 1'b0;
        end
        else
        begin
            // sticky; a full fifo means the transmitter stalled too long, bit is lost
            o_overflow <= o_overflow || (take && !wr_ready);
        end
    end
    logic [3:0] rdata;
    btif_fifo #(.WIDTH(4), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_wr_valid(take),
        .o_wr_ready(wr_ready),
        .i_wr_data(wdata),
        .o_rd_valid(o_tx_valid),
        .i_rd_ready(i_tx_ready),
        .o_rd_data(rdata)
    );
    assign o_tx_pcm_pos = rdata[3];
    assign o_tx_pcm_neg = rdata[2];
    assign o_tx_sig = rdata[1];
    assign o_tx_fbit = rdata[0];
endmodule : btif_port

/* inc/btif_consts.svh */
// constants for the backplane transmit input port
// assumes a 200 MHz system clock sampling a slower backplane clock
// Behaviour
// - port accepts backplane stream at T1 rate or 2.048 Mbit/s, chosen by mode
// - T1 mode: 24 pcm channel bytes per frame, then one framing bit position
// - T1 mode: 24 signalling bytes, nibble in low four bits, then framing bit
// - frame pulse may mark every frame, superframe start or every second superframe
// - 2.048 mode: clock gapped, three bytes kept, filler byte dropped whatever value
// - 2.048 mode: signalling three nibble bytes then filler, converted same way
// - dual-rail T1 mode passes positive and negative rails, violations untouched
`ifndef BTIF_CONSTS_SVH
`define BTIF_CONSTS_SVH
`define BTIF_CHANNELS 5'd24
`define BTIF_LAST_BIT 3'd7
`define BTIF_SLOT_LAST 2'd3
`define BTIF_FILLER_SLOT 2'd3
`define BTIF_SYNC_DEPTH 3
`define BTIF_FIFO_DEPTH 16
`endif

/* inc/btif_pkg.sv */
// types for the backplane transmit input port
// assumes nothing beyond the constants header
package btif_pkg;
    typedef enum logic [1:0] {rate_t1, rate_e1, rate_dual} rate_mode_t;
    typedef enum logic [1:0] {fp_every_frame, fp_superframe, fp_two_superframes} fp_mode_t;
    typedef enum logic [1:0] {st_hunt, st_data, st_fbit} frame_state_t;
endpackage : btif_pkg

/* hdl/btif_fifo.sv */
// parameterised fifo between backplane capture and transmitter
// assumes one clock on both sides
`timescale 1ns/100ps
module btif_fifo #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 16
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_wr_valid,
    output logic o_wr_ready,
    input wire logic [WIDTH-1:0] i_wr_data,
    output logic o_rd_valid,
    input wire logic i_rd_ready,
    output logic [WIDTH-1:0] o_rd_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    logic wr;
    logic rd;
    assign o_wr_ready = (cnt_q != (AW+1)'(DEPTH));
    assign o_rd_valid = (cnt_q != '0);
    assign wr = i_wr_valid && o_wr_ready;
    assign rd = o_rd_valid && i_rd_ready;
    assign o_rd_data = mem_q[rp_q];
    always_ff @(posedge i_clk_sys)
    begin
        if (wr)
        begin
            mem_q[wp_q] <= i_wr_data;
        end
    end
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (wr)
            begin
                wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
            end
            if (rd)
            begin
                rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(wr) - (AW+1)'(rd);
        end
    end
endmodule : btif_fifo

/* tb/btif_port_sva.sv */
// checker for the backplane transmit input port
// assumes binding to btif_port on one clock
`timescale 1ns/100ps
module btif_port_sva #(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic [1:0] i_rate_mode,
    input wire logic i_backplane_tx_clock,
    input wire logic i_backplane_frame_pulse,
    input wire logic o_overflow,
    input wire logic o_tx_valid,
    input wire logic i_tx_ready,
    input wire logic o_tx_pcm_pos,
    input wire logic o_tx_pcm_neg,
    input wire logic o_tx_sig,
    input wire logic o_tx_fbit
);
    // ****
    // helpers
    // ****
    logic [2:0] bp_q;
    logic [7:0] since_q;
    logic fp_seen_q;
    always_ff @(posedge i_clk_sys)
        bp_q <= {bp_q[1:0], i_backplane_tx_clock};
    // saturates, so a silent backplane cannot wrap it
    always_ff @(posedge i_clk_sys)
        if (!i_rst_n || (bp_q[1] && !bp_q[2]))
            since_q <= 8'h00;
        else if (since_q != 8'hff)
            since_q <= since_q + 8'h01;
    always_ff @(posedge i_clk_sys)
        fp_seen_q <= i_rst_n && (fp_seen_q || i_backplane_frame_pulse);
    default clocking @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);
    sequence s_stalled;
        o_tx_valid && !i_tx_ready;
    endsequence
    // ****
    // assertions
    // ****
    a_reset_quiet: assert property ($rose(i_rst_n) |-> !o_tx_valid && !o_overflow)
        else $error("outputs active after reset");
    a_ovf_sticky: assert property (o_overflow |=> o_overflow)
        else $error("overflow flag dropped");
    a_ovf_cause: assert property ($rose(o_overflow) |-> $past(o_tx_valid))
        else $error("overflow with empty fifo");
    a_head_hold: assert property (s_stalled |=> o_tx_valid
        && $stable({o_tx_pcm_pos, o_tx_pcm_neg, o_tx_sig, o_tx_fbit}))
        else $error("head changed while stalled");
    a_pop_needed: assert property ($fell(o_tx_valid) |-> $past(i_tx_ready))
        else $error("entry vanished without pop");
    a_hunt_quiet: assert property (!fp_seen_q |-> !o_tx_valid)
        else $error("data before frame pulse");
    a_neg_single: assert property (o_tx_valid && i_rate_mode != 2'h2 |-> !o_tx_pcm_neg)
        else $error("negative rail outside dual mode");
    a_edge_launch: assert property ($rose(o_tx_valid) |-> since_q inside {[8'h01:8'h0c]})
        else $error("entry not tied to backplane edge");
endmodule : btif_port_sva
bind btif_port btif_port_sva #(.FIFO_DEPTH(FIFO_DEPTH)) u_sva (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_rate_mode(i_rate_mode),
    .i_backplane_tx_clock(i_backplane_tx_clock),
    .i_backplane_frame_pulse(i_backplane_frame_pulse), .o_overflow(o_overflow),
    .o_tx_valid(o_tx_valid), .i_tx_ready(i_tx_ready), .o_tx_pcm_pos(o_tx_pcm_pos),
    .o_tx_pcm_neg(o_tx_pcm_neg), .o_tx_sig(o_tx_sig), .o_tx_fbit(o_tx_fbit)
);

/* tb/btif_bp_model.sv */
// backplane switching side feeding the port
// assumes the bench calls send_bit per bit
`timescale 1ns/100ps
module btif_bp_model (
    output logic o_clk,
    output logic o_pcm,
    output logic o_neg,
    output logic o_sig,
    output logic o_fp
);
    initial
    begin
        {o_clk, o_pcm, o_neg, o_sig, o_fp} = 5'h00;
    end
    // lines move while the clock is low, sampled on its rise
    task automatic send_bit(input logic p, input logic n, input logic s, input logic f);
        {o_pcm, o_neg, o_sig, o_fp} = {p, n, s, f};
        #62.5 o_clk = 1'b1;
        #62.5 o_clk = 1'b0;
    endtask : send_bit
    // clock stands still; stale data must not look valid
    task automatic release_lines();
        {o_pcm, o_neg, o_sig, o_fp} = {~o_pcm, ~o_neg, ~o_sig, 1'b0};
    endtask : release_lines
endmodule : btif_bp_model

/* tb/btif_port_tb_top.sv */
// bench for the backplane transmit input port
// assumes the partner model and a bound checker
`timescale 1ns/100ps
module btif_port_tb_top;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic tx_ready = 1'b1;
    logic [1:0] rate_mode = 2'h0;
    logic [1:0] fp_mode = 2'h0;
    logic bp_clk, bp_pcm, bp_neg, bp_sig, bp_fp, ovf, valid, pos, neg, sig, fbit;
    logic [3:0] got[$];
    logic [3:0] want[$];
    int n_errors = 0;
    int cmp_count = 0;
    initial
    begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    btif_bp_model bp (.o_clk(bp_clk), .o_pcm(bp_pcm), .o_neg(bp_neg), .o_sig(bp_sig), .o_fp(bp_fp));
    btif_port dut (
        .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_rate_mode(rate_mode), .i_fp_mode(fp_mode),
        .i_backplane_tx_clock(bp_clk), .i_backplane_pcm_in(bp_pcm),
        .i_backplane_pcm_neg_in(bp_neg), .i_backplane_signalling_in(bp_sig),
        .i_backplane_frame_pulse(bp_fp), .o_overflow(ovf), .o_tx_valid(valid),
        .i_tx_ready(tx_ready), .o_tx_pcm_pos(pos), .o_tx_pcm_neg(neg), .o_tx_sig(sig),
        .o_tx_fbit(fbit)
    );
    // taken at the falling edge, where head and valid have settled before the pop
    always @(negedge clk_sys)
        if (rst_n && valid && tx_ready)
            got.push_back({pos, neg, sig, fbit});
    task automatic check(input logic c, input string m);
        cmp_count++;
        if (c !== 1'b1)
        begin
            n_errors++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask : check
    function automatic logic [2:0] pat(input int i);
        return {i[0] ^ i[3], ~i[2], i[1] ^ i[4]};
    endfunction : pat
    // negative rail only survives in dual mode
    task automatic put(input logic [3:0] b, input bit keep, input logic fb);
        bp.send_bit(b[3], b[2], b[1], b[0]);
        if (keep)
            want.push_back({b[3], b[2] & (rate_mode == 2'h2), b[1], fb});
    endtask : put
    task automatic compare(input string m);
        int w;
        w = 0;
        bp.release_lines();
        while (got.size() < want.size() && w < 2000)
        begin
            @(posedge clk_sys);
            w++;
        end
        repeat (40) @(posedge clk_sys);
        check(got.size() == want.size(), m);
        foreach (want[i])
            if (i < got.size())
                check(got[i] === want[i], m);
        got.delete();
        want.delete();
    endtask : compare
    task automatic do_reset(input logic [1:0] r, input logic [1:0] f);
        #1 rst_n = 1'b0;
        rate_mode = r;
        fp_mode = f;
        tx_ready = 1'b1;
        repeat (12) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        check(valid === 1'b0 && ovf === 1'b0, "idle after reset");
    endtask : do_reset
    task automatic t1_frame(input logic [1:0] r, input logic [1:0] f);
        do_reset(r, f);
        put(4'b0001, 0, 1'b0);
        for (int i = 0; i < 192; i++)
            put({pat(i), 1'b0}, 1, 1'b0);
        put(4'b1100, 1, 1'b1);
        compare("t1 frame stream");
    endtask : t1_frame
    // filler carries the inverse pattern so a leak would show
    task automatic e1_frame();
        do_reset(2'h1, 2'h0);
        for (int g = 0; g < 8; g++)
        begin
            for (int i = 0; i < 8; i++)
                put({~pat(i), g == 0 && i == 0}, 0, 1'b0);
            for (int i = 0; i < 24; i++)
                put({pat(g * 24 + i), 1'b0}, 1, g == 0 && i == 0);
        end
        compare("2048 frame stream");
    endtask : e1_frame
    task automatic overflow_fill();
        do_reset(2'h0, 2'h0);
        tx_ready = 1'b0;
        put(4'b0001, 0, 1'b0);
        for (int i = 0; i < 20; i++)
            put({pat(i), 1'b0}, i < 16, 1'b0);
        repeat (20) @(posedge clk_sys);
        check(ovf === 1'b1, "overflow not flagged");
        #1 tx_ready = 1'b1;
        compare("fifo drain");
    endtask : overflow_fill
    task automatic conclude();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude
    initial
    begin
        #400000;
        n_errors++;
        $display("CHECK FAILED %0t watchdog expired", $time);
        conclude();
    end
    initial
    begin
        t1_frame(2'h0, 2'h0);
        t1_frame(2'h2, 2'h1);
        t1_frame(2'h0, 2'h2);
        e1_frame();
        overflow_fill();
        conclude();
    end
endmodule : btif_port_tb_top
